// ==== design/mnsc_addr_gen.sv ====
// module: file-register address formation from access bit, bank select and index mode
`timescale 1ns/100ps
`default_nettype none
module mnsc_addr_gen
  import mnsc_pkg::*;
(
  // instruction fields
  input  wire logic        accessBit,
  input  wire logic [7:0]  fileAddr,
  // addressing context
  input  wire logic        extendedEnable,
  input  wire logic [3:0]  bankSelect,
  input  wire logic [11:0] indexBase,
  // result
  output logic      [11:0] dataAddr
);
  always_comb begin
    if (extendedEnable && !accessBit && fileAddr <= INDEXED_MAX) begin
      dataAddr = indexBase + {4'h0, fileAddr};
    end else if (accessBit) begin
      dataAddr = {bankSelect, fileAddr};
    end else if (fileAddr < ACCESS_SPLIT) begin
      dataAddr = {4'h0, fileAddr};
    end else begin
      dataAddr = {ACCESS_HIGH, fileAddr};
    end
  end
endmodule
`default_nettype wire

// ==== design/mnsc_exec.sv ====
// module: decode and execute of multiply, negate, stack, relative call and reset
// Contract
// - literal multiply puts W*k into product pair
// - multiplies leave flags and W unchanged
// - register multiply puts W*f into product pair
// - access bit picks access bank or bank
// - extended set, a=0, f<=5Fh uses indexed offset
// - negate writes two's complement, sets five flags
// - pop discards stack top in one cycle
// - push stores PC+2 on stack top
// - relative call first pushes PC+2
// - call loads PC+2+2n, second cycle idle
// - reset opcode pulses in process phase, resets state in write phase
`timescale 1ns/100ps
`default_nettype none
module mnsc_exec
  import mnsc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  // instruction fetch
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  // addressing context
  input  wire logic        extendedEnable,
  input  wire logic [3:0]  bankSelectIn,
  input  wire logic [11:0] indexBase,
  // working register and data memory
  input  wire logic [7:0]  workReg,
  input  wire logic [7:0]  fileReadData,
  // explicit writes to the product pair
  input  wire logic        productHighWrite,
  input  wire logic        productLowWrite,
  input  wire logic [7:0]  productWriteData,
  // data memory access
  output logic      [11:0] fileAddrOut,
  output logic             fileReadEn,
  output logic             fileWriteEn,
  output logic      [7:0]  fileWriteData,
  // architectural state
  output logic      [7:0]  product_high_byte,
  output logic      [7:0]  product_low_byte,
  output logic      [4:0]  statusFlags,
  output logic      [20:0] programCounter,
  output logic      [20:0] stack_top_entry,
  output logic      [4:0]  stackDepth,
  // core handshake
  output logic      [1:0]  phaseOut,
  output logic             instrDone,
  output logic             softResetPulse
);
  localparam int STACK_DEPTH = 31;

  typedef struct packed {
    mnsc_phase_t phase;
    mnsc_op_t    op;
    logic        idleCycle;
    logic [15:0] instr;
    logic [11:0] addr;
    logic [7:0]  operand;
    logic [15:0] product;
    logic [7:0]  negResult;
    logic [4:0]  negFlags;
    logic [7:0]  prodHigh;
    logic [7:0]  prodLow;
    logic [4:0]  flags;
    logic [20:0] pc;
    logic [4:0]  sp;
    logic [11:0] fAddr;
    logic        fRead;
    logic        fWrite;
    logic [7:0]  fData;
    logic        done;
    logic        swReset;
  } mnsc_state_t;

  mnsc_state_t st_r;
  mnsc_state_t st_nxt;
  logic [20:0] stackMem [STACK_DEPTH];
  logic [11:0] genAddr;
  logic        stackWrite;
  logic [4:0]  stackWrIdx;
  logic [20:0] stackWrData;

  function automatic mnsc_op_t decodeOp(input logic [15:0] w);
    if (w[15:8] == OP_MUL_LIT) decodeOp = EX_MUL_LIT;
    else if (w[15:9] == OP_MUL_REG) decodeOp = EX_MUL_REG;
    else if (w[15:9] == OP_NEGATE) decodeOp = EX_NEGATE;
    else if (w == OP_POP) decodeOp = EX_POP;
    else if (w == OP_PUSH) decodeOp = EX_PUSH;
    else if (w[15:11] == OP_REL_CALL) decodeOp = EX_CALL;
    else if (w == OP_SW_RESET) decodeOp = EX_RESET;
    else decodeOp = EX_NONE;
  endfunction

  mnsc_addr_gen uAddr (
    .accessBit      (st_r.instr[8]),
    .fileAddr       (st_r.instr[7:0]),
    .extendedEnable (extendedEnable),
    .bankSelect     (bankSelectIn),
    .indexBase      (indexBase),
    .dataAddr       (genAddr)
  );

  always_comb begin
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] inv;
    logic [21:0] offset;
    st_nxt      = st_r;
    sum         = 9'h000;
    low         = 5'h00;
    inv         = 8'h00;
    offset      = 22'h000000;
    stackWrite  = 1'b0;
    stackWrIdx  = st_r.sp;
    stackWrData = st_r.pc + PC_STEP;
    st_nxt.fRead  = 1'b0;
    st_nxt.fWrite = 1'b0;
    st_nxt.done   = 1'b0;
    st_nxt.swReset = 1'b0;
    case (st_r.phase)
      PH_DECODE: begin
        st_nxt.instr = instrWord;
        st_nxt.op    = (instrValid && !st_r.idleCycle) ? decodeOp(instrWord) : EX_NONE;
        st_nxt.phase = PH_READ;
      end
      PH_READ: begin
        st_nxt.phase = PH_PROCESS;
        if (st_r.op == EX_MUL_REG || st_r.op == EX_NEGATE) begin
          st_nxt.addr  = genAddr;
          st_nxt.fAddr = genAddr;
          st_nxt.fRead = 1'b1;
        end else if (st_r.op == EX_MUL_LIT) begin
          st_nxt.operand = st_r.instr[7:0];
        end else if (st_r.op == EX_PUSH || st_r.op == EX_CALL) begin
          if (st_r.sp < 5'(STACK_DEPTH)) begin
            stackWrite    = 1'b1;
            st_nxt.sp     = st_r.sp + 5'h01;
          end
        end else if (st_r.op == EX_RESET) begin
          st_nxt.swReset = 1'b1;
        end
      end
      PH_PROCESS: begin
        st_nxt.phase = PH_WRITE;
        if (st_r.op == EX_MUL_REG) begin
          st_nxt.operand = fileReadData;
        end
        if (st_r.op == EX_MUL_REG) begin
          st_nxt.product = workReg * fileReadData;
        end else if (st_r.op == EX_MUL_LIT) begin
          st_nxt.product = workReg * st_r.operand;
        end else if (st_r.op == EX_NEGATE) begin
          inv = ~fileReadData;
          sum = {1'b0, inv} + 9'h001;
          low = {1'b0, inv[3:0]} + 5'h01;
          st_nxt.negResult = sum[7:0];
          st_nxt.negFlags[FLAG_C]  = sum[8];
          st_nxt.negFlags[FLAG_DC] = low[4];
          st_nxt.negFlags[FLAG_Z]  = (sum[7:0] == 8'h00);
          st_nxt.negFlags[FLAG_N]  = sum[7];
          st_nxt.negFlags[FLAG_OV] = (fileReadData == 8'h80);
        end else if (st_r.op == EX_POP && st_r.sp != 5'h00) begin
          st_nxt.sp = st_r.sp - 5'h01;
        end
      end
      PH_WRITE: begin
        st_nxt.phase = PH_DECODE;
        st_nxt.done  = !st_r.idleCycle && st_r.op != EX_CALL;
        st_nxt.idleCycle = 1'b0;
        if (st_r.op == EX_MUL_LIT || st_r.op == EX_MUL_REG) begin
          st_nxt.prodHigh = st_r.product[15:8];
          st_nxt.prodLow  = st_r.product[7:0];
        end else begin
          if (productHighWrite) st_nxt.prodHigh = productWriteData;
          if (productLowWrite) st_nxt.prodLow = productWriteData;
        end
        if (st_r.op == EX_NEGATE) begin
          st_nxt.fAddr  = st_r.addr;
          st_nxt.fWrite = 1'b1;
          st_nxt.fData  = st_r.negResult;
          st_nxt.flags  = st_r.negFlags;
        end
        if (st_r.op == EX_CALL) begin
          offset = {{10{st_r.instr[10]}}, st_r.instr[10:0], 1'b0};
          st_nxt.pc = st_r.pc + PC_STEP + offset[20:0];
          st_nxt.idleCycle = 1'b1;
          st_nxt.op = EX_NONE;
        end else if (st_r.idleCycle) begin
          st_nxt.done = 1'b1;
        end else if (st_r.op != EX_RESET) begin
          st_nxt.pc = st_r.pc + PC_STEP;
        end
        if (st_r.op == EX_RESET) begin
          st_nxt.pc       = RESET_PC;
          st_nxt.sp       = 5'h00;
          st_nxt.flags    = 5'h00;
          st_nxt.prodHigh = RESET_BYTE;
          st_nxt.prodLow  = RESET_BYTE;
        end
      end
      default: st_nxt.phase = PH_DECODE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else if (clkEn) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (clkEn && stackWrite) begin
      stackMem[stackWrIdx] <= stackWrData;
    end
  end

  always_comb begin
    if (st_r.sp == 5'h00) begin
      stack_top_entry = 21'h000000;
    end else begin
      stack_top_entry = stackMem[st_r.sp - 5'h01];
    end
  end

  assign product_high_byte = st_r.prodHigh;
  assign product_low_byte  = st_r.prodLow;
  assign statusFlags       = st_r.flags;
  assign programCounter    = st_r.pc;
  assign stackDepth        = st_r.sp;
  assign fileAddrOut       = st_r.fAddr;
  assign fileReadEn        = st_r.fRead;
  assign fileWriteEn       = st_r.fWrite;
  assign fileWriteData     = st_r.fData;
  assign phaseOut          = st_r.phase;
  assign instrDone         = st_r.done;
  assign softResetPulse    = st_r.swReset;
endmodule
`default_nettype wire

// ==== design/mnsc_pkg.sv ====
// package: opcodes, addressing constants, quarter-cycle phases and reset values
package mnsc_pkg;
  localparam logic [7:0]  OP_MUL_LIT   = 8'h0d;
  localparam logic [6:0]  OP_MUL_REG   = 7'h01;
  localparam logic [6:0]  OP_NEGATE    = 7'h36;
  localparam logic [15:0] OP_POP       = 16'h0006;
  localparam logic [15:0] OP_PUSH      = 16'h0005;
  localparam logic [4:0]  OP_REL_CALL  = 5'h1b;
  localparam logic [15:0] OP_SW_RESET  = 16'h00ff;
  localparam logic [7:0]  INDEXED_MAX  = 8'h5f;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
  localparam logic [20:0] PC_STEP      = 21'h000002;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [20:0] RESET_PC     = 21'h000000;
  localparam int          FLAG_C       = 0;
  localparam int          FLAG_DC      = 1;
  localparam int          FLAG_Z       = 2;
  localparam int          FLAG_OV      = 3;
  localparam int          FLAG_N       = 4;
  typedef enum logic [1:0] {PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} mnsc_phase_t;
  typedef enum logic [2:0] {EX_NONE, EX_MUL_LIT, EX_MUL_REG, EX_NEGATE, EX_POP, EX_PUSH,
                            EX_CALL, EX_RESET} mnsc_op_t;
endpackage

// ==== verification/mnsc_exec_props.sv ====
// checker: phase, product, stack and call timing of the execute block
`timescale 1ns/100ps
`default_nettype none
module mnsc_exec_props
  import mnsc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        clkEn,
  input wire logic [15:0] instrWord,
  input wire logic        instrValid,
  input wire logic [7:0]  workReg,
  input wire logic [7:0]  product_high_byte,
  input wire logic [7:0]  product_low_byte,
  input wire logic [4:0]  statusFlags,
  input wire logic [20:0] programCounter,
  input wire logic [20:0] stack_top_entry,
  input wire logic [4:0]  stackDepth,
  input wire logic [1:0]  phaseOut,
  input wire logic        fileReadEn,
  input wire logic        softResetPulse
);
  logic take;
  assign take = clkEn && instrValid && phaseOut == 2'h0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_phase_step: assert property (clkEn && !reset |=> phaseOut == $past(phaseOut) + 2'h1)
    else $error("phase did not advance");
  a_read_phase: assert property (fileReadEn |-> phaseOut == 2'h2)
    else $error("read outside process phase");
  a_mul_lit: assert property (take && instrWord[15:8] == OP_MUL_LIT |-> ##4
    {product_high_byte, product_low_byte} == 16'($past(workReg, 4)) * 16'($past(instrWord[7:0], 4)))
    else $error("literal product wrong");
  a_mul_flags: assert property (take && (instrWord[15:8] == OP_MUL_LIT ||
    instrWord[15:9] == OP_MUL_REG) |-> ##4 statusFlags == $past(statusFlags, 3))
    else $error("multiply changed flags");
  a_pop_depth: assert property (take && instrWord == OP_POP && stackDepth != 5'h00 |->
    ##3 stackDepth == $past(stackDepth, 3) - 5'h01)
    else $error("pop depth wrong");
  a_push_top: assert property (take && instrWord == OP_PUSH && stackDepth != 5'h1f |->
    ##2 stack_top_entry == $past(programCounter, 1) + PC_STEP)
    else $error("push top wrong");
  a_call_target: assert property (take && instrWord[15:11] == OP_REL_CALL |-> ##4
    programCounter == $past(programCounter, 3) + PC_STEP
    + {{9{$past(instrWord[10], 4)}}, $past(instrWord[10:0], 4), 1'b0})
    else $error("call target wrong");
  a_soft_reset: assert property (take && instrWord == OP_SW_RESET |-> ##2 softResetPulse
    ##2 programCounter == RESET_PC && stackDepth == 5'h00)
    else $error("soft reset wrong");
  c_call: cover property (take && instrWord[15:11] == OP_REL_CALL);
  c_pop: cover property (take && instrWord == OP_POP);
  c_negate: cover property (take && instrWord[15:9] == OP_NEGATE);
endmodule
bind mnsc_exec mnsc_exec_props u_mnsc_exec_props (.*);
`default_nettype wire

// ==== verification/mul_neg_stack_call_exec_tb.sv ====
// testbench: random and corner instruction runs against a reference model
`timescale 1ns/100ps
`default_nettype none
module mul_neg_stack_call_exec_tb;
  import mnsc_pkg::*;
  logic        clk = 1'b0, reset = 1'b1, clkEn = 1'b1, instrValid = 1'b0, extendedEnable = 1'b0;
  logic        productHighWrite = 1'b0, productLowWrite = 1'b0;
  logic [15:0] instrWord = 16'h0000;
  logic [3:0]  bankSelectIn = 4'h0;
  logic [11:0] indexBase = 12'h000, fileAddrOut, addrSeen;
  logic [7:0]  workReg = 8'h00, fileReadData = 8'h00, productWriteData = 8'h00;
  logic [7:0]  fileWriteData, product_high_byte, product_low_byte, d, f, r;
  logic        fileReadEn, fileWriteEn, instrDone, softResetPulse, rdSeen, srSeen, a;
  logic [4:0]  statusFlags, stackDepth, fl = 5'h00;
  logic [20:0] programCounter, stack_top_entry, pc = 21'h0, t1;
  logic [1:0]  phaseOut;
  logic [15:0] prod = 16'h0000;
  logic [10:0] n;
  int          bad_count, n_checks, cyc, dummy;
  mnsc_exec u_mnsc_exec (.*);
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // word is cleared after decode so a long call is not taken twice
  task automatic run(input logic [15:0] w, input int len);
    instrWord  <= w;
    instrValid <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    addrSeen = fileAddrOut;
    rdSeen   = fileReadEn;
    srSeen   = softResetPulse;
    @(posedge clk);
    instrWord <= 16'h0000;
    repeat (len - 3) @(posedge clk);
    #1;
  endtask
  function automatic logic [11:0] ea(input logic acc, input logic [7:0] fa);
    if (acc) return {bankSelectIn, fa};
    if (extendedEnable && fa <= INDEXED_MAX) return indexBase + {4'h0, fa};
    return {(fa < ACCESS_SPLIT) ? 4'h0 : ACCESS_HIGH, fa};
  endfunction
  initial begin
    dummy = $urandom(32'hc4dd);
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 30; i++) begin
      d = (i == 2) ? 8'h80 : (i == 5) ? 8'h00 : 8'($urandom);
      f = (i == 1) ? INDEXED_MAX : (i == 4) ? ACCESS_SPLIT : 8'($urandom);
      a = (i < 6) ? 1'b0 : 1'($urandom);
      extendedEnable <= (i < 6) ? 1'b1 : 1'($urandom);
      bankSelectIn   <= 4'($urandom);
      indexBase      <= 12'($urandom);
      workReg        <= 8'($urandom);
      fileReadData   <= d;
      case (i % 3)
        0: run({OP_MUL_LIT, f}, 4);
        1: run({OP_MUL_REG, a, f}, 4);
        default: run({OP_NEGATE, a, f}, 4);
      endcase
      if (i % 3 == 0) prod = 16'(workReg) * 16'(f);
      if (i % 3 == 1) prod = 16'(workReg) * 16'(d);
      if (i % 3 == 2) begin
        r  = ~d + 8'h01;
        fl = {r[7], d == 8'h80, r == 8'h00, d[3:0] == 4'h0, d == 8'h00};
        check({fileWriteEn, fileWriteData}, {1'b1, r});
      end
      if (i % 3 != 0) check({rdSeen, addrSeen}, {1'b1, ea(a, f)});
      pc = pc + PC_STEP;
      check({product_high_byte, product_low_byte}, prod);
      check(statusFlags, fl);
      check({instrDone, programCounter}, {1'b1, pc});
    end
    // explicit product writes land in the write quarter of a push
    productWriteData <= 8'($urandom);
    productHighWrite <= 1'b1;
    productLowWrite  <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      t1 = pc + PC_STEP;
      run(OP_PUSH, 4);
      if (j == 0) begin
        productHighWrite <= 1'b0;
        productLowWrite  <= 1'b0;
        prod = {productWriteData, productWriteData};
      end
      pc = pc + PC_STEP;
      check(stack_top_entry, t1);
      check({product_high_byte, product_low_byte}, prod);
    end
    // clock enable low freezes phase and program counter
    clkEn <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check({phaseOut, programCounter}, {2'h0, pc});
    clkEn <= 1'b1;
    run(OP_POP, 4);
    pc = pc + PC_STEP;
    check({stack_top_entry, stackDepth, statusFlags}, {t1 - PC_STEP, 5'h01, fl});
    for (int j = 0; j < 3; j++) begin
      n  = (j == 0) ? 11'h400 : (j == 1) ? 11'h3ff : 11'($urandom);
      t1 = pc + PC_STEP;
      run({OP_REL_CALL, n}, 8);
      pc = t1 + {{9{n[10]}}, n, 1'b0};
      check({stack_top_entry, stackDepth}, {t1, 5'(j + 2)});
      check(programCounter, pc);
    end
    run(OP_SW_RESET, 4);
    check(srSeen, 1'b1);
    check({programCounter, stackDepth, statusFlags, product_high_byte, product_low_byte}, 0);
    test_done();
  end
endmodule
`default_nettype wire
